/* hdl/segment_lcd_driver.sv */
`timescale 1ns/10ps
`default_nettype none
module segment_lcd_driver
  import lcd_pkg::*;
(
  input  wire logic         hclk,            // Oscillator reference clock
  input  wire logic         hresetn,         // Async reset, low
  input  wire logic         clk_en,          // Freezes all state when low
  input  wire logic         hsel,            // Slave select
  input  wire logic [31:0]  haddr,           // Byte address
  input  wire logic [1:0]   htrans,          // Transfer type
  input  wire logic         hwrite,          // Write when high
  input  wire logic [31:0]  hwdata,          // Write data
  input  wire logic         hready,          // Bus ready
  output logic              hreadyout,       // Slave ready
  output logic              hresp,           // Always OKAY
  output logic [31:0]       hrdata,          // Read data
  input  wire logic         stop_mode,       // Processor in stop
  input  wire logic         osc_run_in_stop, // Oscillator kept in stop
  output panel_drive_t      panel_drive,     // 28 plane levels
  output logic              ladder_connect,  // Ladder tied to supply
  output logic              ladder_low_res,  // Low-value resistors in use
  output logic [3:0]        contrast_out     // Bias step
);

  bus_state_t   bus_state_reg, bus_state_next;
  logic [29:0]  addr_idx_reg;
  ctrl_t        ctrl_reg;
  clock_t       clock_reg;
  logic [7:0]   seg_reg [SEG_REG_COUNT];
  logic [15:0]  div_cnt_reg;
  logic [1:0]   phase_reg;
  logic [15:0]  fc_cnt_reg;
  panel_drive_t drive_reg, drive_next;
  logic         accept, running, base_tick, half, drive_changed;
  logic [15:0]  limit, fc_len;
  logic [1:0]   last_phase;
  duty_t        duty_eff;

  // Bus slave

  assign accept = hsel && hready && (htrans & HTRANS_NONSEQ_BIT) != 2'h0;

  always_comb begin
    bus_state_next = BUS_IDLE;
    unique case (bus_state_reg)
      BUS_RWAIT: bus_state_next = BUS_RDONE;
      BUS_IDLE, BUS_WRITE, BUS_RDONE: begin
        if (accept) begin
          bus_state_next = hwrite ? BUS_WRITE : BUS_RWAIT;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_reg <= BUS_IDLE;
      addr_idx_reg  <= 30'h0000_0000;
    end else if (clk_en) begin
      bus_state_reg <= bus_state_next;
      if (accept && bus_state_reg != BUS_RWAIT) begin
        addr_idx_reg <= haddr[31:2];
      end
    end
  end

  // Read takes one wait state so a write just before it is already stored
  assign hreadyout = (bus_state_reg != BUS_RWAIT);
  assign hresp     = HRESP_OKAY;

  function automatic logic seg_in_range(input logic [29:0] idx);
    seg_in_range = (idx >= IDX_DATA_FIRST) && (idx <= IDX_DATA_LAST);
  endfunction

  function automatic logic [3:0] seg_slot(input logic [29:0] idx);
    logic [29:0] diff;
    diff     = idx - IDX_DATA_FIRST;
    seg_slot = diff[3:0];
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && bus_state_reg == BUS_RWAIT) begin
      if (addr_idx_reg == IDX_CTRL) begin
        hrdata <= {24'h00_0000, ctrl_reg & CTRL_WMASK};
      end else if (addr_idx_reg == IDX_CLOCK) begin
        hrdata <= {24'h00_0000, clock_reg & CLOCK_WMASK};
      end else if (seg_in_range(addr_idx_reg)) begin
        hrdata <= {24'h00_0000, seg_reg[seg_slot(addr_idx_reg)]};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // Control and clock registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg  <= CTRL_RESET;
      clock_reg <= CLOCK_RESET;
    end else if (clk_en && bus_state_reg == BUS_WRITE) begin
      if (addr_idx_reg == IDX_CTRL) begin
        ctrl_reg <= hwdata[7:0] & CTRL_WMASK;
      end
      if (addr_idx_reg == IDX_CLOCK) begin
        clock_reg <= hwdata[7:0] & CLOCK_WMASK;
      end
    end
  end

  // Segment data is left untouched by reset
  always_ff @(posedge hclk) begin
    if (clk_en && bus_state_reg == BUS_WRITE && seg_in_range(addr_idx_reg)) begin
      if (addr_idx_reg == IDX_DATA_LAST) begin
        seg_reg[seg_slot(addr_idx_reg)] <= hwdata[7:0] & LAST_SEG_WMASK;
      end else begin
        seg_reg[seg_slot(addr_idx_reg)] <= hwdata[7:0];
      end
    end
  end

  // Timing

  // Unused duty code falls back to static
  assign duty_eff   = (clock_reg.duty == DUTY_UNUSED) ? DUTY_STATIC : clock_reg.duty;
  assign last_phase = (duty_eff == DUTY_QUARTER) ? 2'h3 : (duty_eff == DUTY_THIRD) ? 2'h2 : 2'h0;
  assign limit      = div_limit(clock_reg.base_clock_div_sel);
  assign base_tick  = (div_cnt_reg == limit);
  assign half       = (div_cnt_reg > (limit >> 1));

  always_comb begin
    unique case (clock_reg.fast_charge_width)
      2'h1:    fc_len = 16'((32'(limit) + 32'h0000_0001) >> FC_SHIFT_64);
      2'h2:    fc_len = 16'((32'(limit) + 32'h0000_0001) >> FC_SHIFT_128);
      default: fc_len = 16'((32'(limit) + 32'h0000_0001) >> FC_SHIFT_32);
    endcase
  end

  // Wait mode is invisible here; only stop without oscillator halts
  assign running = ctrl_reg.display_enable && !(stop_mode && !osc_run_in_stop);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= 16'h0000;
      phase_reg   <= 2'h0;
    end else if (clk_en) begin
      if (!ctrl_reg.display_enable) begin
        div_cnt_reg <= 16'h0000;
        phase_reg   <= 2'h0;
      end else if (running) begin
        // A shortened divider could leave the count past the new limit
        if (div_cnt_reg >= limit) begin
          div_cnt_reg <= 16'h0000;
          phase_reg   <= (phase_reg >= last_phase) ? 2'h0 : phase_reg + 2'h1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 16'h0001;
          // A shorter duty could leave the phase past the last backplane
          if (phase_reg > last_phase) begin
            phase_reg <= 2'h0;
          end
        end
      end
    end
  end

  // Waveforms

  function automatic logic seg_bit(input int fp, input logic [1:0] bp);
    logic [7:0] word;
    word    = seg_reg[fp / 2];
    seg_bit = word[{fp[0], bp}];
  endfunction

  function automatic logic [1:0] bp_level(input logic active, input logic selected, input logic h);
    if (!active) begin
      bp_level = LVL_VLCD;
    end else if (selected) begin
      bp_level = h ? LVL_V3 : LVL_VLCD;
    end else begin
      bp_level = h ? LVL_V1 : LVL_V2;
    end
  endfunction

  function automatic logic [1:0] fp_level(input duty_t d, input logic on, input logic h);
    if (d == DUTY_STATIC) begin
      fp_level = on ? (h ? LVL_VLCD : LVL_V3) : (h ? LVL_V3 : LVL_VLCD);
    end else begin
      fp_level = on ? (h ? LVL_VLCD : LVL_V3) : (h ? LVL_V2 : LVL_V1);
    end
  endfunction

  always_comb begin
    logic [1:0] bp3;
    bp3        = LVL_VLCD;
    drive_next = '0;
    if (ctrl_reg.display_enable) begin
      for (int b = 0; b < 3; b++) begin
        drive_next.backplane_out[b] = bp_level(2'(b) <= last_phase, phase_reg == 2'(b), half);
      end
      bp3 = bp_level(duty_eff == DUTY_QUARTER, phase_reg == 2'h3, half);
      for (int f = 1; f < 25; f++) begin
        drive_next.frontplane_out[f] = fp_level(duty_eff, seg_bit(f, phase_reg), half);
      end
      if (duty_eff == DUTY_QUARTER) begin
        drive_next.shared_plane_pin = bp3;
      end else begin
        drive_next.shared_plane_pin = fp_level(duty_eff, seg_bit(0, phase_reg), half);
      end
    end
  end

  assign drive_changed = (drive_next != drive_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_reg <= '0;
    end else if (clk_en && (running || !ctrl_reg.display_enable)) begin
      drive_reg <= drive_next;
    end
  end

  assign panel_drive = drive_reg;

  // Ladder control

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fc_cnt_reg     <= 16'h0000;
      ladder_low_res <= 1'h0;
      ladder_connect <= 1'h0;
      contrast_out   <= 4'h0;
    end else if (clk_en && (running || !ctrl_reg.display_enable)) begin
      ladder_connect <= ctrl_reg.display_enable;
      contrast_out   <= ctrl_reg.contrast_sel;
      if (drive_changed) begin
        fc_cnt_reg <= fc_len - 16'h0001;
      end else if (fc_cnt_reg != 16'h0000) begin
        fc_cnt_reg <= fc_cnt_reg - 16'h0001;
      end
      // Low current trades drive strength for ladder current
      ladder_low_res <= !ctrl_reg.low_current_sel ||
                        (ctrl_reg.fast_charge_sel && (drive_changed || fc_cnt_reg != 16'h0000));
    end
  end

  // Checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence ctrl_write_addr_s;
    clk_en && accept && hwrite && haddr[31:2] == IDX_CTRL && bus_state_reg != BUS_RWAIT;
  endsequence

  sequence ctrl_write_data_s;
    clk_en && bus_state_reg == BUS_WRITE;
  endsequence

  disabled_supply_a: assert property (clk_en && !ctrl_reg.display_enable |=> panel_drive == '0)
    else $error("Plane not at supply while display off");

  ladder_off_a: assert property (clk_en && !ctrl_reg.display_enable |=> !ladder_connect)
    else $error("Ladder connected while display off");

  phase_step_a: assert property (clk_en && running && base_tick && last_phase != 2'h0
                                 |=> phase_reg != $past(phase_reg))
    else $error("Phase did not advance at base clock end");

  phase_bound_a: assert property (ctrl_reg.display_enable && clk_en |=> phase_reg <= $past(last_phase) || $changed(clock_reg))
    else $error("Phase beyond active backplanes");

  static_bp_a: assert property (ctrl_reg.display_enable && duty_eff == DUTY_STATIC && running && clk_en
                                |=> panel_drive.backplane_out[1] == LVL_VLCD && panel_drive.backplane_out[2] == LVL_VLCD
                                    || $changed(clock_reg))
    else $error("Idle backplane driven in static duty");

  fc_load_a: assert property (clk_en && running && drive_changed
                              |=> fc_cnt_reg == $past(fc_len) - 16'h0001 &&
                                  ladder_low_res == ($past(!ctrl_reg.low_current_sel) ||
                                                     $past(ctrl_reg.fast_charge_sel)))
    else $error("Fast charge pulse not started on level change");

  low_current_a: assert property (clk_en && running && ctrl_reg.low_current_sel && !ctrl_reg.fast_charge_sel
                                  ##1 clk_en && running && ctrl_reg.low_current_sel && !ctrl_reg.fast_charge_sel
                                  |=> !ladder_low_res)
    else $error("Low current setting ignored");

  stop_freeze_a: assert property (clk_en && ctrl_reg.display_enable && stop_mode && !osc_run_in_stop
                                  |=> $stable(div_cnt_reg) && $stable(panel_drive))
    else $error("Waveform moved while stopped");

  ctrl_write_a: assert property (ctrl_write_addr_s ##1 ctrl_write_data_s |=> ctrl_reg == ($past(hwdata[7:0]) & CTRL_WMASK))
    else $error("Control register write lost");

  shared_role_a: assert property (clk_en && running && duty_eff == DUTY_QUARTER && ctrl_reg.display_enable
                                  |=> panel_drive.shared_plane_pin != LVL_V3 || $past(phase_reg) == 2'h3 ||
                                      $changed(clock_reg))
    else $error("Shared pin not acting as backplane 3");

endmodule // segment_lcd_driver
`default_nettype wire

/* hdl/lcd_pkg.sv */
`default_nettype none
package lcd_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [29:0] IDX_CLOCK      = 30'h0000_004F;
  localparam logic [29:0] IDX_CTRL       = 30'h0000_0051;
  localparam logic [29:0] IDX_DATA_FIRST = 30'h0000_0052;
  localparam logic [29:0] IDX_DATA_LAST  = 30'h0000_005E;
  localparam int          SEG_REG_COUNT  = 13;

  // Reset values and writable bits
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] CLOCK_RESET    = 8'h00;
  localparam logic [7:0] CTRL_WMASK     = 8'hBF;
  localparam logic [7:0] CLOCK_WMASK    = 8'h7F;
  localparam logic [7:0] LAST_SEG_WMASK = 8'h0F;

  // Drive levels: panel supply and three ladder taps
  localparam logic [1:0] LVL_VLCD = 2'h0;
  localparam logic [1:0] LVL_V1   = 2'h1;
  localparam logic [1:0] LVL_V2   = 2'h2;
  localparam logic [1:0] LVL_V3   = 2'h3;

  // Fast charge shifts of the base clock period
  localparam int FC_SHIFT_32  = 5;
  localparam int FC_SHIFT_64  = 6;
  localparam int FC_SHIFT_128 = 7;

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
  localparam logic       HRESP_OKAY        = 1'h0;

  typedef enum logic [1:0] {
    DUTY_STATIC  = 2'h0,
    DUTY_THIRD   = 2'h1,
    DUTY_QUARTER = 2'h2,
    DUTY_UNUSED  = 2'h3
  } duty_t;

  typedef enum logic [3:0] {
    BUS_IDLE  = 4'h1,
    BUS_WRITE = 4'h2,
    BUS_RWAIT = 4'h4,
    BUS_RDONE = 4'h8
  } bus_state_t;

  typedef struct packed {
    logic       display_enable;
    logic       reserved;
    logic       fast_charge_sel;
    logic       low_current_sel;
    logic [3:0] contrast_sel;
  } ctrl_t;

  typedef struct packed {
    logic       reserved;
    logic [1:0] fast_charge_width;
    duty_t      duty;
    logic [2:0] base_clock_div_sel;
  } clock_t;

  typedef struct packed {
    logic [24:1][1:0] frontplane_out;
    logic [1:0]       shared_plane_pin;
    logic [2:0][1:0]  backplane_out;
  } panel_drive_t;

  // Reference clocks per base clock period, minus one
  function automatic logic [15:0] div_limit(input logic [2:0] sel);
    unique case (sel)
      3'h0:    div_limit = 16'h007F;
      3'h1:    div_limit = 16'h00FF;
      3'h2:    div_limit = 16'h01FF;
      3'h3:    div_limit = 16'h03FF;
      3'h4:    div_limit = 16'h3FFF;
      3'h5:    div_limit = 16'h7FFF;
      default: div_limit = 16'hFFFF;
    endcase
  endfunction

endpackage
`default_nettype wire

/* bench/lcd_glass.sv */
`timescale 1ns/10ps
`default_nettype none
module lcd_glass
  import lcd_pkg::*;
(
  input  wire logic         hclk,        // Reference clock
  input  wire logic         hresetn,     // Async reset, low
  input  wire panel_drive_t panel_drive, // Plane levels from driver
  input  wire logic         clear,       // Forget seen peaks
  output logic [24:0][3:0]  lit          // Full supply seen per segment
);
  logic [1:0] fp [25];
  logic [1:0] bp [4];
  always_comb begin
    for (int f = 1; f < 25; f++) begin
      fp[f] = panel_drive.frontplane_out[f];
    end
    fp[0] = panel_drive.shared_plane_pin;
    for (int b = 0; b < 3; b++) begin
      bp[b] = panel_drive.backplane_out[b];
    end
    bp[3] = panel_drive.shared_plane_pin;
  end
  // Only supply facing bias darkens a segment; tap pairs stay below threshold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lit <= '0;
    end else begin
      for (int f = 0; f < 25; f++) begin
        for (int b = 0; b < 4; b++) begin
          lit[f][b] <= !clear && (lit[f][b] || {fp[f], bp[b]} == 4'h3 || {fp[f], bp[b]} == 4'hC);
        end
      end
    end
  end
endmodule // lcd_glass
`default_nettype wire

/* bench/segment_lcd_driver_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH %0t value %0h expected %0h", $time, (got), (exp)); end end
module segment_lcd_driver_tb
  import lcd_pkg::*;
;
  logic             hclk, hresetn, clk_en, hsel, hwrite, stop_mode, osc_run_in_stop, clear;
  logic [31:0]      haddr, hwdata, hrdata;
  logic [1:0]       htrans;
  logic             hreadyout, hresp, ladder_connect, ladder_low_res;
  logic [3:0]       contrast_out;
  panel_drive_t     panel_drive;
  logic [24:0][3:0] lit;
  logic [7:0]       seg [1:13];
  int               n_fail, checks_done;

  segment_lcd_driver uut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .stop_mode(stop_mode), .osc_run_in_stop(osc_run_in_stop),
    .panel_drive(panel_drive), .ladder_connect(ladder_connect), .ladder_low_res(ladder_low_res),
    .contrast_out(contrast_out));
  lcd_glass glass (.hclk(hclk), .hresetn(hresetn), .panel_drive(panel_drive), .clear(clear), .lit(lit));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [29:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'b00};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ_BIT;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    `CHK(hresp, HRESP_OKAY)
  endtask

  task automatic wr(input logic [29:0] idx, input logic [7:0] d);
    logic [31:0] r;
    ahb(1'b1, idx, d, r);
  endtask

  task automatic chk_rd(input logic [29:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, idx, 8'h00, r);
    `CHK(r, exp)
  endtask

  function automatic logic seg_bit(input int f, input int b);
    return seg[f / 2 + 1][(f % 2) * 4 + b];
  endfunction

  task automatic t_reset();
    chk_rd(IDX_CTRL, 32'h0000_0000);
    chk_rd(IDX_CLOCK, 32'h0000_0000);
    `CHK(panel_drive, '0)
    `CHK(ladder_connect, 1'b0)
  endtask

  task automatic t_regs();
    logic [29:0] ia [5] = '{IDX_CTRL, IDX_CLOCK, IDX_DATA_LAST, 30'h0000_0050, IDX_DATA_FIRST};
    logic [7:0]  ea [5] = '{8'hBF, 8'h7F, 8'h0F, 8'h00, 8'hFF};
    for (int i = 0; i < 5; i++) begin
      wr(ia[i], 8'hFF);
      chk_rd(ia[i], {24'h00_0000, ea[i]});
    end
    wr(IDX_CTRL, 8'h00);
  endtask

  task automatic t_data();
    for (int n = 1; n <= SEG_REG_COUNT; n++) begin
      seg[n] = 8'(n * 8'h2B + 8'h17) & ((n == 13) ? 8'h0F : 8'hFF);
      wr(IDX_DATA_FIRST + 30'(n - 1), seg[n]);
      chk_rd(IDX_DATA_FIRST + 30'(n - 1), {24'h00_0000, seg[n]});
    end
  endtask

  // One frame of counting is enough: the waveform is periodic in the frame
  task automatic t_duty(input duty_t d, input int nbp, input logic [2:0] div, input int ratio);
    int cnt [4];
    wr(IDX_CLOCK, {3'b000, d, div});
    wr(IDX_CTRL, 8'h80);
    repeat (2 * ratio * nbp) @(posedge hclk);
    `CHK(ladder_connect, 1'b1)
    while (panel_drive.backplane_out[0] === LVL_V3) @(posedge hclk);
    while (panel_drive.backplane_out[0] !== LVL_V3) @(posedge hclk);
    repeat (ratio) @(posedge hclk);
    if (nbp > 1) `CHK(panel_drive.backplane_out[1], LVL_V3)
    `CHK(panel_drive.backplane_out[0] === LVL_V3, nbp == 1)
    clear <= 1'b1;
    @(posedge hclk);
    clear <= 1'b0;
    cnt = '{default: 0};
    repeat (nbp * ratio) begin
      @(posedge hclk);
      for (int b = 0; b < 3; b++) cnt[b] += int'(panel_drive.backplane_out[b] === LVL_V3);
      cnt[3] += int'(panel_drive.shared_plane_pin === LVL_V3);
    end
    for (int b = 0; b < 4; b++) begin
      if (b < 3 || nbp == 4) `CHK(cnt[b], (b < nbp) ? ratio / 2 : 0)
    end
    for (int f = (nbp == 4) ? 1 : 0; f < 25; f++) begin
      for (int b = 0; b < nbp; b++) `CHK(lit[f][b], seg_bit(f, b))
    end
  endtask

  task automatic t_fast();
    int w [4] = '{4, 2, 1, 4};
    int n;
    panel_drive_t p;
    for (int c = 0; c < 4; c++) begin
      wr(IDX_CLOCK, {1'b0, 2'(c), DUTY_QUARTER, 3'h0});
      wr(IDX_CTRL, 8'hB0);
      repeat (200) @(posedge hclk);
      while (ladder_low_res === 1'b1) @(posedge hclk);
      while (ladder_low_res !== 1'b1) begin
        p = panel_drive;
        @(posedge hclk);
      end
      `CHK(panel_drive !== p, 1'b1)
      n = 0;
      while (ladder_low_res === 1'b1 && n < 200) begin
        n++;
        @(posedge hclk);
      end
      `CHK(n, w[c])
    end
    for (int m = 0; m < 2; m++) begin
      wr(IDX_CTRL, m ? 8'h80 : 8'h90);
      repeat (2) @(posedge hclk);
      n = 0;
      repeat (256) begin
        @(posedge hclk);
        n += int'(ladder_low_res === 1'b1);
      end
      `CHK(n, m ? 256 : 0)
    end
  endtask

  task automatic t_contrast();
    for (int c = 0; c < 16; c++) begin
      wr(IDX_CTRL, 8'h80 | 8'(c));
      repeat (2) @(posedge hclk);
      `CHK(contrast_out, 4'(c))
    end
  endtask

  // Stop without oscillator and a gated clock must both freeze; stop with it must not
  task automatic t_stop();
    panel_drive_t p;
    logic ch;
    for (int k = 0; k < 3; k++) begin
      @(posedge hclk);
      clk_en          <= (k != 1);
      stop_mode       <= (k != 1);
      osc_run_in_stop <= (k == 2);
      repeat (3) @(posedge hclk);
      p  = panel_drive;
      ch = 1'b0;
      repeat (300) begin
        @(posedge hclk);
        ch |= (panel_drive !== p);
      end
      `CHK(ch, k == 2)
      clk_en    <= 1'b1;
      stop_mode <= 1'b0;
      chk_rd(IDX_CTRL, 32'h0000_008F);
    end
  endtask

  task automatic t_disable();
    wr(IDX_CTRL, 8'h00);
    repeat (3) @(posedge hclk);
    `CHK(panel_drive, '0)
    `CHK(ladder_connect, 1'b0)
  endtask

  initial begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    stop_mode = 1'b0;
    osc_run_in_stop = 1'b0;
    clear = 1'b0;
    n_fail = 0;
    checks_done = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_regs();
    t_data();
    t_duty(DUTY_QUARTER, 4, 3'h1, 256);
    t_duty(DUTY_THIRD, 3, 3'h0, 128);
    t_duty(DUTY_STATIC, 1, 3'h0, 128);
    t_duty(DUTY_UNUSED, 1, 3'h0, 128);
    t_fast();
    t_contrast();
    t_stop();
    t_disable();
    summarize();
  end

  initial begin
    #400_000;
    n_fail++;
    summarize();
  end
endmodule // segment_lcd_driver_tb
`default_nettype wire
